// ### common/hst_pkg.sv
// Purpose: Shared constants and types for the HD sync table engine.
// Assumes: One pixel clock domain; host bytes arrive already decoded from the serial port.
// Notes: Table images are kept as packed byte arrays so both modules agree on layout.
package hst_pkg;

  // Raster coordinate width.
  localparam int XY_W = 12;

  // Table port subaddresses.
  localparam logic [7:0] SUB_LINE_COUNT = 8'hd0;
  localparam logic [7:0] SUB_LINE_TYPE = 8'hd1;
  localparam logic [7:0] SUB_LINE_PATTERN = 8'hd2;
  localparam logic [7:0] SUB_VALUE = 8'hd3;

  // Array selector codes held by the host port.
  localparam logic [2:0] ARR_NONE = 3'h0;
  localparam logic [2:0] ARR_CNT = 3'h1;
  localparam logic [2:0] ARR_TYP = 3'h2;
  localparam logic [2:0] ARR_PAT = 3'h3;
  localparam logic [2:0] ARR_VAL = 3'h4;

  // Last byte index inside one entry of each array.
  localparam logic [2:0] CNT_LAST_B = 3'h1;
  localparam logic [2:0] TYP_LAST_B = 3'h3;
  localparam logic [2:0] PAT_LAST_B = 3'h7;
  localparam logic [2:0] VAL_LAST_B = 3'h1;

  // First and last entry index of each array.
  localparam logic [3:0] CNT_FIRST_E = 4'h0;
  localparam logic [3:0] CNT_LAST_E = 4'hf;
  localparam logic [3:0] TYP_FIRST_E = 4'h1;
  localparam logic [3:0] TYP_LAST_E = 4'hf;
  localparam logic [3:0] PAT_FIRST_E = 4'h1;
  localparam logic [3:0] PAT_LAST_E = 4'h7;
  localparam logic [3:0] VAL_FIRST_E = 4'h0;
  localparam logic [3:0] VAL_LAST_E = 4'h7;

  // Field positions: type index in a count entry's second byte, g_only bit in a pair's value index, sync bits in a value entry's second byte.
  localparam int HI_IDX_LSB = 4;
  localparam int VAL_GONLY_BIT = 3;
  localparam int VAL_HS_BIT = 0;
  localparam int VAL_VS_BIT = 1;

  // Last pair index per pattern entry and last slot index per line type entry.
  localparam logic [1:0] PAIR_LAST = 2'h3;
  localparam logic [2:0] SLOT_LAST = 3'h7;

  // One host byte event.
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [7:0] data;
  } hst_host_t;

  // Raster geometry and trigger coordinate.
  typedef struct packed {
    logic [XY_W-1:0] width;
    logic [XY_W-1:0] height;
    logic [XY_W-1:0] trig_x;
    logic [XY_W-1:0] trig_y;
  } hst_raster_t;

  // Byte images of all four tables.
  typedef struct packed {
    logic [31:0][7:0] cnt;
    logic [63:0][7:0] typ;
    logic [63:0][7:0] pat;
    logic [15:0][7:0] val;
  } hst_tables_t;

  // Outgoing insertion word.
  typedef struct packed {
    logic active;
    logic g_only;
    logic [7:0] level;
    logic hs;
    logic vs;
  } hst_video_t;

  // Host port state.
  typedef struct packed {
    logic [2:0] arr;
    logic first;
    logic [3:0] entry;
    logic [2:0] bidx;
    logic [7:0] rdata;
    hst_tables_t tab;
  } hst_port_t;

  // Sequencer state.
  typedef struct packed {
    logic [XY_W-1:0] x;
    logic [XY_W-1:0] y;
    logic seq_on;
    logic [3:0] cidx;
    logic [9:0] rep;
    logic [2:0] slot;
    logic [1:0] pair;
    logic [11:0] dur;
    logic trig;
    hst_video_t vid;
  } hst_seq_t;

endpackage

// ### verilog/hst_table_port.sv
// Purpose: Byte-wise host access to the line count, line type, line pattern and value tables.
// Assumes: A select event carries a subaddress; write and read events carry or return one byte.
// Notes: Pointers are shared, so reselecting a port always needs a fresh pointer byte.
`timescale 1ns/100ps
`default_nettype none
module hst_table_port import hst_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Host byte events.
  input wire hst_host_t host,
  // Read data, valid the cycle after a read event.
  output logic [7:0] rd_data,
  // Table images for the sequencer.
  output var hst_tables_t tab
);

  // Register and next value of the whole port state.
  hst_port_t q, d;

  // Last byte index of one entry of the chosen array.
  function automatic logic [2:0] last_byte(input logic [2:0] arr);
    if (arr == ARR_CNT) begin
      return CNT_LAST_B;
    end else if (arr == ARR_TYP) begin
      return TYP_LAST_B;
    end else if (arr == ARR_PAT) begin
      return PAT_LAST_B;
    end else begin
      return VAL_LAST_B;
    end
  endfunction

  // First valid entry index of the chosen array.
  function automatic logic [3:0] first_entry(input logic [2:0] arr);
    if (arr == ARR_TYP) begin
      return TYP_FIRST_E;
    end else if (arr == ARR_PAT) begin
      return PAT_FIRST_E;
    end else begin
      return CNT_FIRST_E;
    end
  endfunction

  // Last valid entry index of the chosen array.
  function automatic logic [3:0] last_entry(input logic [2:0] arr);
    if (arr == ARR_PAT) begin
      return PAT_LAST_E;
    end else if (arr == ARR_VAL) begin
      return VAL_LAST_E;
    end else begin
      return CNT_LAST_E;
    end
  endfunction

  // Next state: subaddress decode, pointer load, byte storage and readback.
  always_comb begin
    d = q;
    if (host.sel) begin
      // Subaddress decode; anything else parks the port.
      if (host.data == SUB_LINE_COUNT) begin
        d.arr = ARR_CNT;
      end else if (host.data == SUB_LINE_TYPE) begin
        d.arr = ARR_TYP;
      end else if (host.data == SUB_LINE_PATTERN) begin
        d.arr = ARR_PAT;
      end else if (host.data == SUB_VALUE) begin
        d.arr = ARR_VAL;
      end else begin
        d.arr = ARR_NONE;
      end
      d.first = 1'b1;
    end else if (host.wr && q.arr != ARR_NONE && q.first) begin
      // The first byte is the entry pointer, offset by the array's first index.
      d.entry = host.data[3:0] + first_entry(q.arr);
      if (d.entry > last_entry(q.arr) || d.entry < first_entry(q.arr)) begin
        d.entry = first_entry(q.arr);
      end
      d.bidx = 3'h0;
      d.first = 1'b0;
    end else if ((host.wr || host.rd) && q.arr != ARR_NONE) begin
      // Store or fetch one byte at the pointer.
      if (q.arr == ARR_CNT) begin
        d.rdata = q.tab.cnt[{q.entry, q.bidx[0]}];
        if (host.wr) begin
          d.tab.cnt[{q.entry, q.bidx[0]}] = host.data;
        end
      end else if (q.arr == ARR_TYP) begin
        d.rdata = q.tab.typ[{q.entry, q.bidx[1:0]}];
        if (host.wr) begin
          d.tab.typ[{q.entry, q.bidx[1:0]}] = host.data;
        end
      end else if (q.arr == ARR_PAT) begin
        d.rdata = q.tab.pat[{q.entry[2:0], q.bidx}];
        if (host.wr) begin
          d.tab.pat[{q.entry[2:0], q.bidx}] = host.data;
        end
      end else begin
        d.rdata = q.tab.val[{q.entry[2:0], q.bidx[0]}];
        if (host.wr) begin
          d.tab.val[{q.entry[2:0], q.bidx[0]}] = host.data;
        end
      end
      // Step the pointer; a finished entry moves on to the next one and wraps.
      if (q.bidx == last_byte(q.arr)) begin
        d.bidx = 3'h0;
        d.entry = (q.entry == last_entry(q.arr)) ? first_entry(q.arr) : q.entry + 4'h1;
      end else begin
        d.bidx = q.bidx + 3'h1;
      end
    end
  end

  // State register; tables clear to zero so unused slots read as empty.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rdata;
  assign tab = q.tab;

endmodule
`default_nettype wire

// ### verilog/hst_sync_engine.sv
// Purpose: Table-driven sync raster engine producing per-pixel insertion values.
// Assumes: Host events come decoded from the serial control port, one per pixel clock.
// Notes: A line ends when its last used pattern pair expires, so tables must sum to the line length.
`timescale 1ns/100ps
`default_nettype none
module hst_sync_engine import hst_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Raster geometry and trigger coordinate.
  input wire hst_raster_t raster,
  // Host byte events and readback.
  input wire hst_host_t host,
  output logic [7:0] rd_data,
  // Trigger pulse and insertion word.
  output logic trig,
  output var hst_video_t video
);

  // Table images held by the host port.
  hst_tables_t tab;

  // Sequencer state and its next value.
  hst_seq_t q, d;

  // Pair and slot lookups for the current state.
  logic [3:0] cur_type;
  logic [3:0] cur_pidx;
  logic [15:0] cur_pair;
  logic [3:0] cur_vidx;
  logic [3:0] nxt_pidx;
  logic [15:0] nxt_pair;
  logic match;
  logic line_done;
  logic [3:0] new_cidx;
  logic [9:0] new_rep;
  logic [3:0] new_type;

  // Host-facing table storage.
  hst_table_port u_port (
    .clk(clk),
    .rstn(rstn),
    .host(host),
    .rd_data(rd_data),
    .tab(tab)
  );

  // Repeat count of one line count entry.
  function automatic logic [9:0] cnt_count(input hst_tables_t t, input logic [3:0] ci);
    return {t.cnt[{ci, 1'b1}][1:0], t.cnt[{ci, 1'b0}]};
  endfunction

  // Line type index of one line count entry.
  function automatic logic [3:0] cnt_type(input hst_tables_t t, input logic [3:0] ci);
    return t.cnt[{ci, 1'b1}][HI_IDX_LSB +: 4];
  endfunction

  // Pattern index held in one slot of a line type; type zero is never a real entry.
  function automatic logic [3:0] typ_slot(input hst_tables_t t, input logic [3:0] ti, input logic [2:0] sl);
    logic [7:0] b;
    b = t.typ[{ti, sl[2:1]}];
    if (ti == 4'h0) begin
      return 4'h0;
    end else begin
      return sl[0] ? b[7:4] : b[3:0];
    end
  endfunction

  // One duration/value pair; indices above seven or zero read as empty.
  function automatic logic [15:0] pat_pair(input hst_tables_t t, input logic [3:0] pi, input logic [1:0] pr);
    if (pi == 4'h0 || pi > PAT_LAST_E) begin
      return 16'h0000;
    end else begin
      return {t.pat[{pi[2:0], pr, 1'b1}], t.pat[{pi[2:0], pr, 1'b0}]};
    end
  endfunction

  // Duration minus one of a pair: twelve bits split over both bytes.
  function automatic logic [11:0] pair_dur(input logic [15:0] p);
    return {p[11:8], p[7:0]};
  endfunction

  // Current lookups from the sequencer state.
  always_comb begin
    cur_type = cnt_type(tab, q.cidx);
    cur_pidx = typ_slot(tab, cur_type, q.slot);
    cur_pair = pat_pair(tab, cur_pidx, q.pair);
    cur_vidx = cur_pair[15:12];
    match = (q.x == raster.trig_x) && (q.y == raster.trig_y);
    // Next slot index, read only when the pairs of this slot run out.
    nxt_pidx = (q.slot == SLOT_LAST) ? 4'h0 : typ_slot(tab, cur_type, q.slot + 3'h1);
    nxt_pair = (q.pair == PAIR_LAST) ? 16'h0000 : pat_pair(tab, cur_pidx, q.pair + 2'h1);
    line_done = (q.dur == 12'h000) && (nxt_pair == 16'h0000) && (nxt_pidx == 4'h0);
    // Line bookkeeping: repeat the entry, else step and restart at the end.
    if (q.rep + 10'h001 >= cnt_count(tab, q.cidx)) begin
      new_rep = 10'h000;
      if (q.cidx == CNT_LAST_E || cnt_count(tab, q.cidx + 4'h1) == 10'h000) begin
        new_cidx = CNT_FIRST_E;
      end else begin
        new_cidx = q.cidx + 4'h1;
      end
    end else begin
      new_rep = q.rep + 10'h001;
      new_cidx = q.cidx;
    end
    new_type = cnt_type(tab, new_cidx);
  end

  // Next state of raster counter, sequencer and output word.
  always_comb begin
    d = q;
    d.trig = 1'b0;
    // Raster counter wraps at the programmed width and height.
    if (q.x >= raster.width - 1'b1) begin
      d.x = '0;
      d.y = (q.y >= raster.height - 1'b1) ? '0 : q.y + 1'b1;
    end else begin
      d.x = q.x + 1'b1;
    end
    // Registered insertion word from the pair being played now.
    d.vid.active = q.seq_on;
    d.vid.g_only = q.seq_on & cur_vidx[VAL_GONLY_BIT];
    d.vid.level = q.seq_on ? tab.val[{cur_vidx[2:0], 1'b0}] : 8'h00;
    d.vid.hs = q.seq_on & tab.val[{cur_vidx[2:0], 1'b1}][VAL_HS_BIT];
    d.vid.vs = q.seq_on & tab.val[{cur_vidx[2:0], 1'b1}][VAL_VS_BIT];
    if (match) begin
      // Trigger reloads every pointer to its first entry.
      d.trig = 1'b1;
      d.seq_on = 1'b1;
      d.cidx = CNT_FIRST_E;
      d.rep = 10'h000;
      d.slot = 3'h0;
      d.pair = 2'h0;
      d.dur = pair_dur(pat_pair(tab, typ_slot(tab, cnt_type(tab, CNT_FIRST_E), 3'h0), 2'h0));
    end else if (q.seq_on) begin
      if (q.dur != 12'h000) begin
        d.dur = q.dur - 12'h001;
      end else if (nxt_pair != 16'h0000) begin
        // Next pair of the same pattern.
        d.pair = q.pair + 2'h1;
        d.dur = pair_dur(nxt_pair);
      end else if (nxt_pidx != 4'h0) begin
        // Next pattern slot of the same line type; zero slots end the line.
        d.slot = q.slot + 3'h1;
        d.pair = 2'h0;
        d.dur = pair_dur(pat_pair(tab, nxt_pidx, 2'h0));
      end else if (line_done) begin
        // Line finished: move through the line count sequence.
        d.rep = new_rep;
        d.cidx = new_cidx;
        d.slot = 3'h0;
        d.pair = 2'h0;
        d.dur = pair_dur(pat_pair(tab, typ_slot(tab, new_type, 3'h0), 2'h0));
      end
    end
  end

  // State register; nothing plays until the first trigger.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign trig = q.trig;
  assign video = q.vid;

endmodule
`default_nettype wire

// ### tb/hst_sync_engine_checker.sv
// Purpose: Port-level assertions for the sync engine.
// Assumes: Raster inputs stay constant between resets.
// Notes: The frame period is judged only from the second trigger after reset.
`timescale 1ns/100ps
`default_nettype none
module hst_sync_engine_checker import hst_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Watched ports.
  input wire hst_raster_t raster,
  input wire hst_host_t host,
  input wire logic [7:0] rd_data,
  input wire logic trig,
  input wire hst_video_t video
);
  // Set once a trigger has been seen since reset.
  logic seen_q;
  // Cycles since the last trigger.
  logic [31:0] per_q;

  // Trigger history, so one frame can be measured edge to edge.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen_q <= 1'b0;
      per_q <= 32'h0;
    end else begin
      seen_q <= seen_q | trig;
      per_q <= trig ? 32'h1 : per_q + 32'h1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_trig_single: assert property (trig |=> !trig) else $error("trigger held too long");
  chk_frame_period: assert property (trig && seen_q |-> per_q == 32'(raster.width) * 32'(raster.height))
    else $error("trigger period differs from raster size");
  chk_trig_start: assert property (trig |=> video.active) else $error("sequencer not started");
  chk_active_holds: assert property (video.active |=> video.active) else $error("sequence stopped");
  chk_active_cause: assert property ($rose(video.active) |-> $past(trig)) else $error("start without trigger");
  chk_idle_quiet: assert property (!video.active |-> video == '0) else $error("output while idle");
  chk_rd_hold: assert property (!host.rd && !host.wr |=> $stable(rd_data)) else $error("read data moved");
  chk_quiet_first: assert property (!seen_q |-> video == '0) else $error("output before trigger");
endmodule
bind hst_sync_engine hst_sync_engine_checker u_chk (.clk(clk), .rstn(rstn), .raster(raster), .host(host),
  .rd_data(rd_data), .trig(trig), .video(video));
`default_nettype wire

// ### tb/hst_host_model.sv
// Purpose: Host side that loads and reads the sync tables byte by byte.
// Assumes: One host event per clock, launched just after the rising edge.
// Notes: An event is held until the next one replaces it, so events run back to back.
`timescale 1ns/100ps
`default_nettype none
module hst_host_model import hst_pkg::*; (
  // Clock.
  input wire logic clk,
  // Readback from the engine.
  input wire logic [7:0] rd_data,
  // Byte events to the engine.
  output var hst_host_t host
);
  initial host = '0;

  // One event, taken at the next edge.
  task ev(input logic s, input logic w, input logic r, input logic [7:0] d);
    host = '{sel: s, wr: w, rd: r, data: d};
    @(posedge clk);
    #2;
  endtask

  // Every access reselects the port and sets a fresh pointer, so a readback never steers a write.
  task open(input logic [7:0] sub, input logic [7:0] ptr);
    ev(1'b1, 1'b0, 1'b0, sub);
    ev(1'b0, 1'b1, 1'b0, ptr);
  endtask

  // Writes one data byte.
  task put(input logic [7:0] d);
    ev(1'b0, 1'b1, 1'b0, d);
  endtask

  // Reads one byte; it is valid once the read edge has passed.
  task get(output logic [7:0] v);
    ev(1'b0, 1'b0, 1'b1, 8'h00);
    v = rd_data;
  endtask

  // Releases the port; the data lines flip so a stale byte never looks valid.
  task idle();
    ev(1'b0, 1'b0, 1'b0, ~host.data);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_hd_sync_table_engine.sv
// Purpose: Self-checking bench for the sync table engine.
// Assumes: A 40x5 raster with its trigger at 3,1.
// Notes: The loaded tables give lines of 9, 9 and 4 cycles, then the sequence restarts.
`timescale 1ns/100ps
`default_nettype none
module tb_hd_sync_table_engine import hst_pkg::*;;
  // One table load: subaddress, pointer byte, byte count, bytes from the left.
  typedef struct packed {logic [7:0] sub; logic [7:0] ptr; logic [3:0] n; logic [63:0] b;} hst_row_t;
  logic clk;
  logic rstn;
  hst_raster_t raster;
  hst_host_t host;
  logic [7:0] rd_data;
  logic trig;
  hst_video_t video;
  int checks = 0;
  int num_errors = 0;
  logic [7:0] v;
  // Values, then patterns before line types, then counts.
  hst_row_t rows [5] = '{'{8'hd3, 8'h01, 4'h6, 64'h1101220233030000},
    '{8'hd2, 8'h00, 4'h8, 64'h021001a000000000}, '{8'hd2, 8'h01, 4'h8, 64'h0330000000000000},
    '{8'hd1, 8'h00, 4'h8, 64'h2100000002000000}, '{8'hd0, 8'h00, 4'h6, 64'h0210012000000000}};

  hst_sync_engine u_hst_sync_engine (.clk(clk), .rstn(rstn), .raster(raster), .host(host),
    .rd_data(rd_data), .trig(trig), .video(video));
  hst_host_model u_host (.clk(clk), .rd_data(rd_data), .host(host));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Counts a comparison and reports a mismatch at once.
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Reads n bytes from a fresh pointer and compares the last one.
  task peek(input logic [7:0] sub, input logic [7:0] ptr, input int n, input logic [7:0] exp);
    u_host.open(sub, ptr);
    repeat (n) u_host.get(v);
    chk({4'h0, v}, {4'h0, exp});
  endtask

  // Expects one value for n pixel clocks.
  task seg(input logic g, input logic [7:0] lv, input logic [1:0] b1, input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
      chk(video, {1'b1, g, lv, b1[0], b1[1]});
    end
  endtask

  // Line type 1: pattern 1 then pattern 2.
  task line1();
    seg(1'b0, 8'h11, 2'h1, 3);
    seg(1'b1, 8'h22, 2'h2, 2);
    seg(1'b0, 8'h33, 2'h3, 4);
  endtask

  task report_and_stop();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    num_errors++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    raster = '{12'h028, 12'h005, 12'h003, 12'h001};
    repeat (16) @(posedge clk);
    #2 rstn = 1'b1;
    chk(video, 12'h0);
    // Each row is written, then read back through a fresh pointer.
    foreach (rows[r]) begin
      u_host.open(rows[r].sub, rows[r].ptr);
      for (int i = 0; i < rows[r].n; i++) u_host.put(rows[r].b[63 - 8 * i -: 8]);
      u_host.open(rows[r].sub, rows[r].ptr);
      for (int i = 0; i < rows[r].n; i++) begin
        u_host.get(v);
        chk({4'h0, v}, {4'h0, rows[r].b[63 - 8 * i -: 8]});
      end
    end
    // Pointer limits, wraps and a refused subaddress.
    peek(8'hd2, 8'h07, 1, 8'h02);
    peek(8'hd0, 8'h0f, 3, 8'h02);
    peek(8'hd1, 8'h0e, 5, 8'h21);
    // A value pointer past entry seven falls back to entry zero, so the third byte is entry one's level.
    peek(8'hd3, 8'h0b, 3, 8'h11);
    u_host.open(8'hd5, 8'h00);
    u_host.put(8'h55);
    peek(8'hd0, 8'h00, 1, 8'h02);
    u_host.idle();
    // The stream starts the cycle after the trigger and restarts once the counts are used up.
    for (int k = 0; k < 400 && trig !== 1'b1; k++) begin
      @(posedge clk);
      #2;
    end
    chk({11'h0, trig}, 12'h1);
    repeat (2) begin
      repeat (2) line1();
      seg(1'b0, 8'h33, 2'h3, 4);
    end
    // Reset in mid-run clears outputs and tables.
    rstn = 1'b0;
    #2;
    chk(video, 12'h0);
    @(posedge clk);
    #2 rstn = 1'b1;
    peek(8'hd2, 8'h00, 1, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
